// file: cfw_core.sv
/*
 * core housekeeping: indirect port, pointer, work register, flags,
 * watchdog, halt and wake-up, instruction clock enable and clk_out_pin
 * assumes the core sequencer issues accesses and ops on iclk_en cycles
 */
`timescale 1ns/1ps
`default_nettype none
module cfw_core
    import cfw_pkg::*;
#(
    parameter int DOG_N = CFW_DOG_N_DEFAULT,
    parameter bit DOG_ENABLE = 1'b1,
    parameter bit DOG_DOUBLE = 1'b0,
    parameter bit RC_OSC = 1'b1,
    parameter logic [7:0] WAKE_ENABLE = 8'hff,
    parameter int WAKE_CYCLES = CFW_WAKE_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ext_rst_pin,
    input wire logic [7:0] wake_port_b,
    input wire cfw_mem_req_type mem_req,
    output logic [7:0] mem_rdata,
    output logic ram_we,
    output logic [5:0] ram_addr,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    input wire cfw_alu_req_type alu_req,
    input wire cfw_op_type op,
    output logic [7:0] work_out,
    output logic [7:0] flags_out,
    output logic iclk_en,
    output logic run_en,
    output logic halted,
    output logic chip_reset,
    output logic clk_out_pin
);
    // ************************************************
    // instruction clock and output clock
    // ************************************************
    logic [1:0] phase_ff;
    logic clk_out_ff;
    logic halted_ff;
    logic [10:0] wake_cnt_ff;
    logic waking_ff;

    // oscillator stops in halt, so the phase freezes too
    always_ff @(posedge clock) begin
        if (!rstn) begin
            phase_ff <= 2'h0;
        end else if (!halted_ff) begin
            phase_ff <= phase_ff + 2'h1;
        end
    end
    assign iclk_en = (phase_ff == 2'h3) && !halted_ff && !waking_ff;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            clk_out_ff <= 1'b0;
        end else begin
            clk_out_ff <= RC_OSC ? phase_ff[1] : 1'b0;
        end
    end
    assign clk_out_pin = clk_out_ff;

    // ************************************************
    // watchdog
    // ************************************************
    logic [CFW_DOG_N_MAX-1:0] dog_ff;
    logic kick1_seen_ff;
    logic kick2_seen_ff;
    logic dog_clear;
    logic dog_timeout;
    logic op_now;
    logic halt_now;
    logic kick_now;
    logic kick1_now;
    logic kick2_now;

    // ops count only on the instruction clock edge
    assign op_now = iclk_en;
    assign halt_now = op_now && op == CFW_OP_HALT;
    assign kick_now = op_now && op == CFW_OP_KICK;
    assign kick1_now = op_now && op == CFW_OP_KICK1;
    assign kick2_now = op_now && op == CFW_OP_KICK2;

    // disabled watchdog: every kick form falls through as a no-op
    always_comb begin
        dog_clear = 1'b0;
        if (DOG_ENABLE) begin
            if (!DOG_DOUBLE) begin
                dog_clear = kick_now;
            end else if ((kick1_now && kick2_seen_ff) || (kick2_now && kick1_seen_ff)) begin
                // double form: clear once both halves are seen, in either order
                dog_clear = 1'b1;
            end
        end
    end
    assign dog_timeout = DOG_ENABLE && iclk_en
        && (dog_ff[DOG_N-1:0] == {DOG_N{1'b1}});

    always_ff @(posedge clock) begin
        if (!rstn || !ext_rst_pin || chip_reset) begin
            kick1_seen_ff <= 1'b0;
            kick2_seen_ff <= 1'b0;
        end else if (dog_clear) begin
            kick1_seen_ff <= 1'b0;
            kick2_seen_ff <= 1'b0;
        end else if (DOG_ENABLE && DOG_DOUBLE) begin
            if (kick1_now) begin
                kick1_seen_ff <= 1'b1;
            end
            if (kick2_now) begin
                kick2_seen_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || !ext_rst_pin) begin
            dog_ff <= '0;
        // halt clears the prescaler too, so a wake-up starts a full period
        end else if (dog_clear || halt_now || dog_timeout) begin
            dog_ff <= '0;
        end else if (DOG_ENABLE && iclk_en) begin
            dog_ff <= dog_ff + 11'h001;
        end
    end

    // time-out resets the chip for one cycle; pc and sp live outside
    always_ff @(posedge clock) begin
        if (!rstn) begin
            chip_reset <= 1'b0;
        end else begin
            chip_reset <= dog_timeout || !ext_rst_pin;
        end
    end

    // ************************************************
    // halt and wake-up
    // ************************************************
    logic [7:0] port_prev_ff;
    logic port_wake;

    // starts at the pull-high idle level, so no false edge follows reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            port_prev_ff <= 8'hff;
        end else begin
            port_prev_ff <= wake_port_b;
        end
    end
    assign port_wake = |(port_prev_ff & ~wake_port_b & WAKE_ENABLE);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            halted_ff <= 1'b0;
            waking_ff <= 1'b0;
            wake_cnt_ff <= 11'h000;
        end else if (halted_ff && (!ext_rst_pin || port_wake)) begin
            halted_ff <= 1'b0;
            waking_ff <= 1'b1;
            wake_cnt_ff <= 11'h000;
        end else if (halt_now) begin
            halted_ff <= 1'b1;
        end else if (waking_ff) begin
            if (wake_cnt_ff == 11'(WAKE_CYCLES - 1)) begin
                waking_ff <= 1'b0;
            end else begin
                wake_cnt_ff <= wake_cnt_ff + 11'h001;
            end
        end
    end
    assign halted = halted_ff;
    assign run_en = !halted_ff && !waking_ff;

    // ************************************************
    // registers and indirect access
    // ************************************************
    logic [5:0] pointer_ff;
    logic [7:0] work_ff;
    logic [7:0] flags_word;
    logic [5:0] eff_addr;
    logic via_port;
    logic acc_ok;

    assign via_port = mem_req.addr == CFW_ADDR_INDIRECT;
    assign eff_addr = via_port ? pointer_ff : mem_req.addr;
    assign acc_ok = !(via_port && pointer_ff == CFW_ADDR_INDIRECT);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pointer_ff <= 6'h00;
        end else if (mem_req.wr && acc_ok && eff_addr == CFW_ADDR_POINTER) begin
            pointer_ff <= mem_req.wdata[5:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            work_ff <= 8'h00;
        end else if (mem_req.wr && acc_ok && eff_addr == CFW_ADDR_WORK) begin
            work_ff <= mem_req.wdata;
        end
    end
    assign work_out = work_ff;

    // general ram is outside; strobe only for its range
    assign ram_addr = eff_addr;
    assign ram_wdata = mem_req.wdata;
    assign ram_we = mem_req.wr && acc_ok && eff_addr >= CFW_ADDR_RAM_LO;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            mem_rdata <= 8'h00;
        end else if (mem_req.rd) begin
            if (!acc_ok) begin
                mem_rdata <= CFW_ZERO_BYTE;
            end else if (eff_addr == CFW_ADDR_POINTER) begin
                mem_rdata <= {CFW_POINTER_PAD, pointer_ff};
            end else if (eff_addr == CFW_ADDR_WORK) begin
                mem_rdata <= work_ff;
            end else if (eff_addr == CFW_ADDR_FLAGS) begin
                mem_rdata <= flags_word;
            end else if (eff_addr >= CFW_ADDR_RAM_LO) begin
                mem_rdata <= ram_rdata;
            end else begin
                mem_rdata <= CFW_ZERO_BYTE;
            end
        end
    end

    // ************************************************
    // flag generation
    // ************************************************
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] sum7;
    logic [7:0] bop;
    logic nxt_c;
    logic nxt_h;
    logic nxt_v;

    // subtract as a + ~b + cin, so carry out means no borrow
    always_comb begin
        bop = (alu_req.kind == CFW_ALU_SUB) ? ~alu_req.b : alu_req.b;
        sum9 = {1'b0, alu_req.a} + {1'b0, bop} + {8'h00, alu_req.cin};
        sum5 = {1'b0, alu_req.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, alu_req.cin};
        sum7 = {1'b0, alu_req.a[6:0]} + {1'b0, bop[6:0]} + {7'h00, alu_req.cin};
        nxt_c = sum9[8];
        nxt_h = sum5[4];
        nxt_v = sum7[7] ^ sum9[8];
    end

    logic [3:0] arith_ff;
    logic sleep_ff;
    logic expired_ff;
    logic flag_wr;

    assign flag_wr = mem_req.wr && acc_ok && eff_addr == CFW_ADDR_FLAGS;

    // calls never touch these flags; software saves them itself
    // a software write beats an alu update on the same edge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            arith_ff <= 4'h0;
        end else if (flag_wr) begin
            arith_ff <= mem_req.wdata[3:0] & CFW_FLAGS_SW_MASK[3:0];
        end else if (alu_req.valid) begin
            arith_ff[CFW_BIT_ZERO] <= alu_req.result == 8'h00;
            if (alu_req.kind == CFW_ALU_ROT) begin
                arith_ff[CFW_BIT_CARRY] <= alu_req.rot_carry;
            end else if (alu_req.kind != CFW_ALU_LOGIC) begin
                arith_ff[CFW_BIT_CARRY] <= nxt_c;
                arith_ff[CFW_BIT_HALF] <= nxt_h;
                arith_ff[CFW_BIT_WRAP] <= nxt_v;
            end
        end
    end

    // no software write reaches sleep or expired
    // time-out wins over halt or kick on one edge; it must never be lost
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sleep_ff <= 1'b0;
        end else if (halt_now && !dog_timeout) begin
            sleep_ff <= 1'b1;
        end else if (dog_clear && !dog_timeout) begin
            sleep_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            expired_ff <= 1'b0;
        end else if (dog_timeout) begin
            expired_ff <= 1'b1;
        end else if (halt_now || dog_clear) begin
            expired_ff <= 1'b0;
        end else if (halted_ff && !ext_rst_pin) begin
            expired_ff <= 1'b0;
        end
    end

    // unused top bits read zero
    always_comb begin
        flags_word = 8'h00;
        flags_word[3:0] = arith_ff;
        flags_word[CFW_BIT_SLEEP] = sleep_ff;
        flags_word[CFW_BIT_EXPIRED] = expired_ff;
    end
    assign flags_out = flags_word;
endmodule
`default_nettype wire

// file: cfw_core_chk.sv
/* assertions on the housekeeping core ports
   assumes one clock domain and the synchronous active-low rstn */
`timescale 1ns/1ps
`default_nettype none
module cfw_core_chk
    import cfw_pkg::*;
#(
    parameter int WAKE_CYCLES = CFW_WAKE_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ext_rst_pin,
    input wire cfw_mem_req_type mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic ram_we,
    input wire logic [5:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    input wire cfw_alu_req_type alu_req,
    input wire cfw_op_type op,
    input wire logic [7:0] flags_out,
    input wire logic iclk_en,
    input wire logic run_en,
    input wire logic halted,
    input wire logic chip_reset
);
    // ************
    // helpers
    // ************
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [8:0] add9;
    logic [4:0] low5;
    logic [11:0] wait_cnt_ff;
    logic woke_ff;
    logic flag_wr;
    assign add9 = {1'b0, alu_req.a} + {1'b0, alu_req.b} + {8'h00, alu_req.cin};
    assign low5 = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]} + {4'h0, alu_req.cin};
    assign flag_wr = mem_req.wr && mem_req.addr == CFW_ADDR_FLAGS;
    always_ff @(posedge clock) begin
        if (!rstn || halted || run_en) begin
            wait_cnt_ff <= 12'h000;
        end else begin
            wait_cnt_ff <= wait_cnt_ff + 12'h001;
        end
    end
    // only port wake-ups are timed; a pin reset wake-up waits too but is left unchecked
    always_ff @(posedge clock) begin
        if (!rstn || run_en) begin
            woke_ff <= 1'b0;
        end else if ($fell(halted) && ext_rst_pin) begin
            woke_ff <= 1'b1;
        end
    end
    sequence halt_taken;
        iclk_en && op == CFW_OP_HALT && ext_rst_pin;
    endsequence
    sequence asleep;
        halted && flags_out[5:4] == 2'h1;
    endsequence
    // ************
    // assertions
    // ************
    AST_FLAGS_TOP: assert property (flags_out[7:6] == 2'h0)
        else $error("flag bits 7..6 not zero");
    AST_HALT_ENTRY: assert property (halt_taken |=> asleep)
        else $error("halt entry flags wrong");
    AST_HALT_STILL: assert property (halted |-> !iclk_en && !run_en)
        else $error("instruction clock runs in halt");
    AST_KICK: assert property (iclk_en && op == CFW_OP_KICK && ext_rst_pin
        |=> chip_reset || flags_out[5:4] == 2'h0) else $error("kick left flags set");
    AST_ICLK: assert property (iclk_en |=> !iclk_en [*3])
        else $error("instruction clock not clock over four");
    AST_WAKE_WAIT: assert property ($rose(run_en) && woke_ff |-> wait_cnt_ff == WAKE_CYCLES)
        else $error("wake wait length wrong");
    AST_PTR_PAD: assert property (mem_req.rd && mem_req.addr == CFW_ADDR_POINTER
        |=> mem_rdata[7:6] == CFW_POINTER_PAD) else $error("pointer top bits not one");
    AST_RAM_WRITE: assert property (mem_req.wr && mem_req.addr >= CFW_ADDR_RAM_LO
        |-> ram_we && ram_addr == mem_req.addr && ram_wdata == mem_req.wdata)
        else $error("ram write not passed on");
    AST_RAM_READ: assert property (mem_req.rd && mem_req.addr >= CFW_ADDR_RAM_LO
        |=> mem_rdata == $past(ram_rdata)) else $error("ram read data wrong");
    AST_TIMEOUT: assert property (chip_reset && ext_rst_pin && $past(ext_rst_pin)
        |-> flags_out[5]) else $error("time-out without expired flag");
    AST_ADD_FLAGS: assert property (alu_req.valid && alu_req.kind == CFW_ALU_ADD && !flag_wr
        |=> flags_out[1:0] == $past({low5[4], add9[8]})) else $error("add carry flags wrong");
    AST_ZERO: assert property (alu_req.valid && alu_req.kind != CFW_ALU_ROT && !flag_wr
        |=> flags_out[2] == $past(alu_req.result == 8'h00)) else $error("zero flag wrong");
    AST_SW_KEEP: assert property (flag_wr && !(iclk_en && op != CFW_OP_NONE)
        |=> chip_reset || flags_out[5:4] == $past(flags_out[5:4]))
        else $error("write changed sleep or expired flag");
endmodule
bind cfw_core cfw_core_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.clock(clock), .rstn(rstn),
    .ext_rst_pin(ext_rst_pin), .mem_req(mem_req), .mem_rdata(mem_rdata), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .alu_req(alu_req),
    .op(op), .flags_out(flags_out), .iclk_en(iclk_en), .run_en(run_en), .halted(halted),
    .chip_reset(chip_reset));
`default_nettype wire

// file: cfw_pkg.sv
/*
 * constants, register map and carrier types for the core housekeeping block
 * assumes one 40 MHz system clock; the core drives the data-memory port
 */
package cfw_pkg;
    localparam logic [5:0] CFW_ADDR_INDIRECT = 6'h00;
    localparam logic [5:0] CFW_ADDR_POINTER = 6'h01;
    localparam logic [5:0] CFW_ADDR_WORK = 6'h05;
    localparam logic [5:0] CFW_ADDR_FLAGS = 6'h0a;
    localparam logic [5:0] CFW_ADDR_RAM_LO = 6'h20;
    localparam logic [5:0] CFW_ADDR_RAM_HI = 6'h3f;
    localparam logic [7:0] CFW_ZERO_BYTE = 8'h00;
    localparam logic [1:0] CFW_POINTER_PAD = 2'h3;
    // flag bit positions
    localparam int CFW_BIT_CARRY = 0;
    localparam int CFW_BIT_HALF = 1;
    localparam int CFW_BIT_ZERO = 2;
    localparam int CFW_BIT_WRAP = 3;
    localparam int CFW_BIT_SLEEP = 4;
    localparam int CFW_BIT_EXPIRED = 5;
    localparam logic [7:0] CFW_FLAGS_SW_MASK = 8'h0f;
    // timing
    localparam int CFW_CLK_HZ = 40000000;
    localparam int CFW_ICLK_DIV = 4;
    localparam int CFW_WAKE_TSYS = 1024;
    localparam int CFW_WAKE_CYCLES = CFW_WAKE_TSYS;
    localparam int CFW_DOG_N_DEFAULT = 8;
    localparam int CFW_DOG_N_MAX = 11;

    typedef enum logic [2:0] {
        CFW_OP_NONE,
        CFW_OP_KICK,
        CFW_OP_KICK1,
        CFW_OP_KICK2,
        CFW_OP_HALT
    } cfw_op_type;

    typedef enum logic [1:0] {
        CFW_ALU_LOGIC,
        CFW_ALU_ADD,
        CFW_ALU_SUB,
        CFW_ALU_ROT
    } cfw_alu_type;

    // one flag update from the alu
    typedef struct packed {
        logic valid;
        cfw_alu_type kind;
        logic [7:0] a;
        logic [7:0] b;
        logic cin;
        logic rot_carry;
        logic [7:0] result;
    } cfw_alu_req_type;

    // one data-memory access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } cfw_mem_req_type;
endpackage

// file: cfw_ram_model.sv
/* data ram beside the housekeeping core, 20h..3fh
   assumes combinational read on ram_addr and write on ram_we at the edge */
`timescale 1ns/1ps
`default_nettype none
module cfw_ram_model
    import cfw_pkg::*;
(
    input wire logic clock,
    input wire logic ram_we,
    input wire logic [5:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata
);
    // ************
    // storage
    // ************
    logic [7:0] mem [32];
    logic [7:0] junk_ff = 8'h5a;
    always_ff @(posedge clock) begin
        junk_ff <= ~junk_ff;
        if (ram_we && ram_addr >= CFW_ADDR_RAM_LO) begin
            mem[ram_addr[4:0]] <= ram_wdata;
        end
    end
    // not selected: a changing pattern, never a stale value
    assign ram_rdata = (ram_addr >= CFW_ADDR_RAM_LO) ? mem[ram_addr[4:0]] : junk_ff;
endmodule
`default_nettype wire

// file: testbench.sv
/* self-checking bench for the housekeeping core
   assumes the ram model and the bound checker; wake wait shortened to 16 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cfw_pkg::*;
    // ************
    // wiring
    // ************
    logic clock = 1'b0, rstn = 1'b0, ext_rst_pin = 1'b1;
    logic [7:0] wake_port_b = 8'hff;
    cfw_mem_req_type mem_req = '0;
    cfw_alu_req_type alu_req = '0;
    cfw_op_type op = CFW_OP_NONE;
    logic [7:0] mem_rdata, ram_wdata, ram_rdata, work_out, flags_out;
    logic [5:0] ram_addr;
    logic ram_we, iclk_en, run_en, halted, chip_reset, clk_out_pin;
    int errors = 0, checked = 0, cycles = 0, resets = 0, n, rs;
    cfw_core #(.WAKE_CYCLES(16)) uut (.clock(clock), .rstn(rstn), .ext_rst_pin(ext_rst_pin),
        .wake_port_b(wake_port_b), .mem_req(mem_req), .mem_rdata(mem_rdata), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .alu_req(alu_req),
        .op(op), .work_out(work_out), .flags_out(flags_out), .iclk_en(iclk_en),
        .run_en(run_en), .halted(halted), .chip_reset(chip_reset), .clk_out_pin(clk_out_pin));
    cfw_ram_model ram (.clock(clock), .ram_we(ram_we), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
    initial begin
        forever #12.5 clock = ~clock;
    end
    // ************
    // tasks
    // ************
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        mem_req = '{1'b0, 1'b1, a, d};
        tick(1);
        mem_req = '0;
        tick(1);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        mem_req = '{1'b1, 1'b0, a, 8'h00};
        tick(1);
        mem_req = '0;
        chk8(mem_rdata, exp);
        tick(1);
    endtask
    task automatic do_op(input cfw_op_type o);
        while (iclk_en !== 1'b1) tick(1);
        op = o;
        tick(1);
        op = CFW_OP_NONE;
        tick(1);
    endtask
    task automatic alu(input cfw_alu_type k, input logic [7:0] a, input logic [7:0] b,
        input logic c, input logic rc, input logic [7:0] res, input logic [7:0] m,
        input logic [7:0] exp);
        wr(CFW_ADDR_FLAGS, 8'h00);
        alu_req = '{1'b1, k, a, b, c, rc, res};
        tick(1);
        alu_req = '0;
        chk8(flags_out & m, exp);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (chip_reset === 1'b1) resets++;
        // whole run needs about 4000 clocks
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    // ************
    // tests
    // ************
    initial begin
        tick(5);
        rstn = 1'b1;
        rd(CFW_ADDR_POINTER, 8'hc0);
        rd(CFW_ADDR_FLAGS, 8'h00);
        wr(CFW_ADDR_POINTER, 8'hff);
        rd(CFW_ADDR_POINTER, 8'hff);
        wr(6'h25, 8'ha5);
        wr(CFW_ADDR_POINTER, 8'h25);
        rd(CFW_ADDR_INDIRECT, 8'ha5);
        wr(CFW_ADDR_INDIRECT, 8'h5a);
        rd(6'h25, 8'h5a);
        wr(CFW_ADDR_POINTER, 8'h00);
        wr(CFW_ADDR_INDIRECT, 8'h77);
        rd(CFW_ADDR_INDIRECT, 8'h00);
        rd(CFW_ADDR_POINTER, 8'hc0);
        rd(6'h03, 8'h00);
        wr(CFW_ADDR_FLAGS, 8'hff);
        rd(CFW_ADDR_FLAGS, 8'h0f);
        alu(CFW_ALU_ADD, 8'h0f, 8'h01, 1'b0, 1'b0, 8'h10, 8'h0f, 8'h02);
        alu(CFW_ALU_ADD, 8'hff, 8'h01, 1'b0, 1'b0, 8'h00, 8'h0f, 8'h07);
        alu(CFW_ALU_ADD, 8'h7f, 8'h01, 1'b0, 1'b0, 8'h80, 8'h0f, 8'h0a);
        alu(CFW_ALU_SUB, 8'h05, 8'h03, 1'b1, 1'b0, 8'h02, 8'h0f, 8'h03);
        alu(CFW_ALU_SUB, 8'h03, 8'h05, 1'b1, 1'b0, 8'hfe, 8'h0f, 8'h00);
        alu(CFW_ALU_LOGIC, 8'h55, 8'haa, 1'b0, 1'b0, 8'h00, 8'h04, 8'h04);
        alu(CFW_ALU_ROT, 8'h80, 8'h00, 1'b0, 1'b1, 8'h00, 8'h01, 8'h01);
        wr(CFW_ADDR_WORK, 8'h3c);
        do_op(CFW_OP_HALT);
        chk8(flags_out & 8'h30, 8'h10);
        rs = resets;
        tick(1200);
        chk8({halted, 7'(resets - rs)}, 8'h80);
        wake_port_b = 8'hfe;
        tick(1);
        wake_port_b = 8'hff;
        while (run_en !== 1'b1) tick(1);
        rd(CFW_ADDR_WORK, 8'h3c);
        chk8(work_out, 8'h3c);
        chk8({halted, 7'(resets - rs)}, 8'h00);
        do_op(CFW_OP_HALT);
        ext_rst_pin = 1'b0;
        tick(4);
        ext_rst_pin = 1'b1;
        while (run_en !== 1'b1) tick(1);
        chk8({halted, flags_out[6:0] & 7'h30}, 8'h10);
        do_op(CFW_OP_KICK);
        chk8(flags_out & 8'h30, 8'h00);
        rs = resets;
        repeat (8) begin
            do_op(CFW_OP_KICK);
            tick(200);
        end
        chk8(8'(resets - rs), 8'h00);
        do_op(CFW_OP_KICK);
        n = 0;
        while (chip_reset !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        // 256 instruction clocks of four system clocks, give or take two
        chk8({7'h00, n >= 1016 && n <= 1032}, 8'h01);
        chk8({7'h00, flags_out[5]}, 8'h01);
        n = 0;
        repeat (16) begin
            rs = clk_out_pin;
            tick(1);
            n += (clk_out_pin === 1'b1 && rs == 0);
        end
        chk8(8'(n), 8'h04);
        finish_test();
    end
endmodule
`default_nettype wire
